/* hw/dual_io_port.sv */
// two 8-bit general-purpose i/o ports sharing pins with display segment outputs
//
// Functional notes
// - each data register holds eight bits driven onto pins configured as outputs.
// - reading a port returns stored data for pins whose direction bit is one.
// - reading a port returns the sampled pin level where direction bit is zero.
// - direction bit one makes a pin output, zero input, each bit independently.
// - direction and data act only while the segment select gives the pin to gpio.
// - direction registers are write only and always read as all ones.
// - reset clears data and direction registers, so every pin starts as input.
// - port 7 is gpio for select 00xx; otherwise pin n drives segment n+17.
// - port 8 bit 7: clock when extended select set, else segment 32 for 001x up.
// - pins float in reset and standby, hold in sleep, work normally otherwise.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "dual_io_map.svh"

module dual_io_port (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // power mode from the system controller, same clock
    input  wire logic        standby_mode,
    input  wire logic        sleep_mode,
    // display controller outputs, same clock; bit k is segment k+17
    input  wire logic [15:0] segment_output,
    input  wire logic        display_clock_one,
    // port 7 pins
    input  wire logic [7:0]  p7_pin_in,
    output logic      [7:0]  p7_pin_out,
    output logic      [7:0]  p7_pin_oe,
    // port 8 pins
    input  wire logic [7:0]  p8_pin_in,
    output logic      [7:0]  p8_pin_out,
    output logic      [7:0]  p8_pin_oe
);

    // ------------------------------------------------------------
    // address map
    // ------------------------------------------------------------

    // byte addresses are four times the register index
    localparam logic [31:0] ADDR_P7_DATA   = {14'h0000, `DIO_P7_DATA_IDX, 2'b00};
    localparam logic [31:0] ADDR_P8_DATA   = {14'h0000, `DIO_P8_DATA_IDX, 2'b00};
    localparam logic [31:0] ADDR_P7_DIR    = {14'h0000, `DIO_P7_DIR_IDX, 2'b00};
    localparam logic [31:0] ADDR_P8_DIR    = {14'h0000, `DIO_P8_DIR_IDX, 2'b00};
    localparam logic [31:0] ADDR_DISP_CTRL = {14'h0000, `DIO_DISP_CTRL_IDX, 2'b00};

    // ------------------------------------------------------------
    // state and pin inputs
    // ------------------------------------------------------------

    dual_io_pkg::dio_state_t s_q;
    dual_io_pkg::dio_state_t s_d;

    logic [15:0] pins_synced;
    logic [7:0]  p7_level;
    logic [7:0]  p8_level;

    // pins are asynchronous to pclk, so both ports pass two flops
    pin_sync u_pin_sync (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin_async  ({p8_pin_in, p7_pin_in}),
        .pin_synced (pins_synced)
    );

    assign p7_level = pins_synced[7:0];
    assign p8_level = pins_synced[15:8];

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------

    logic setup_phase;
    logic access_done;
    logic wr_en;
    logic hit_p7_data;
    logic hit_p8_data;
    logic hit_p7_dir;
    logic hit_p8_dir;
    logic hit_ctrl;
    logic hit_any;

    // the slave answers in the first access cycle; pready is set from setup
    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable & s_q.pready;
    assign wr_en       = access_done & pwrite;

    // address compare against every register
    assign hit_p7_data = (paddr == ADDR_P7_DATA);
    assign hit_p8_data = (paddr == ADDR_P8_DATA);
    assign hit_p7_dir  = (paddr == ADDR_P7_DIR);
    assign hit_p8_dir  = (paddr == ADDR_P8_DIR);
    assign hit_ctrl    = (paddr == ADDR_DISP_CTRL);
    assign hit_any     = hit_p7_data | hit_p8_data | hit_p7_dir | hit_p8_dir | hit_ctrl;

    // ------------------------------------------------------------
    // pin function decode
    // ------------------------------------------------------------

    // port 7 goes to segments for any select code other than 00xx
    logic p7_seg_mode;
    // port 8 goes to segments for any code other than 000x, except the top pin while extended select is set
    logic p8_seg_mode;
    dual_io_pkg::pin_fn_t p8_bit7_fn;

    assign p7_seg_mode = (s_q.seg_sel[3:2] != 2'b00);
    assign p8_seg_mode = (s_q.seg_sel[3:1] != 3'b000);

    // extended select takes the top pin from the segment driver for the clock
    always_comb begin
        if (s_q.extended_display_select) begin
            p8_bit7_fn = dual_io_pkg::FN_CLOCK;
        end else if (p8_seg_mode) begin
            p8_bit7_fn = dual_io_pkg::FN_SEGMENT;
        end else begin
            p8_bit7_fn = dual_io_pkg::FN_GPIO;
        end
    end

    // ------------------------------------------------------------
    // per-pin output mux and read-back
    // ------------------------------------------------------------

    logic [7:0] p7_fn_out;
    logic [7:0] p7_fn_oe;
    logic [7:0] p8_fn_out;
    logic [7:0] p8_fn_oe;
    logic [7:0] p7_readback;
    logic [7:0] p8_readback;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
            // port 7 pin: segment gi+17 or gpio
            assign p7_fn_out[gi] = p7_seg_mode ? segment_output[gi]
                                               : s_q.p7_data[gi];
            assign p7_fn_oe[gi]  = p7_seg_mode | s_q.p7_dir[gi];

            // read-back: stored data for outputs, pin level for inputs
            assign p7_readback[gi] = s_q.p7_dir[gi] ? s_q.p7_data[gi]
                                                    : p7_level[gi];
            assign p8_readback[gi] = s_q.p8_dir[gi] ? s_q.p8_data[gi]
                                                    : p8_level[gi];

            // port 8 pins: the top one may also carry the display clock
            if (gi == 7) begin : g_top
                always_comb begin
                    unique case (p8_bit7_fn)
                        dual_io_pkg::FN_CLOCK: begin
                            p8_fn_out[gi] = display_clock_one;
                            p8_fn_oe[gi]  = 1'b1;
                        end
                        dual_io_pkg::FN_SEGMENT: begin
                            p8_fn_out[gi] = segment_output[8 + gi];
                            p8_fn_oe[gi]  = 1'b1;
                        end
                        dual_io_pkg::FN_GPIO: begin
                            p8_fn_out[gi] = s_q.p8_data[gi];
                            p8_fn_oe[gi]  = s_q.p8_dir[gi];
                        end
                        default: begin
                            p8_fn_out[gi] = 1'b0;
                            p8_fn_oe[gi]  = 1'b0;
                        end
                    endcase
                end
            end else begin : g_low
                // lower port 8 pins: segment gi+25 under the same codes
                assign p8_fn_out[gi] = p8_seg_mode ? segment_output[8 + gi]
                                                   : s_q.p8_data[gi];
                assign p8_fn_oe[gi]  = p8_seg_mode | s_q.p8_dir[gi];
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // read data select
    // ------------------------------------------------------------

    logic [31:0] rd_value;

    // direction registers cannot be read back; software must shadow them
    always_comb begin
        rd_value = `DIO_UNMAPPED_READ;
        if (hit_p7_data) begin
            rd_value = {24'h00_0000, p7_readback};
        end else if (hit_p8_data) begin
            rd_value = {24'h00_0000, p8_readback};
        end else if (hit_p7_dir || hit_p8_dir) begin
            rd_value = `DIO_DIR_READ_VALUE;
        end else if (hit_ctrl) begin
            rd_value = {27'h000_0000, s_q.extended_display_select, s_q.seg_sel};
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------

    always_comb begin
        s_d = s_q;

        // bus answer: ready for exactly the first access cycle
        s_d.pready  = setup_phase;
        s_d.pslverr = setup_phase & ~hit_any;
        if (setup_phase) begin
            // read data sampled at setup, so the pin level is one cycle old
            s_d.prdata = pwrite ? `DIO_UNMAPPED_READ : rd_value;
        end else if (access_done) begin
            s_d.prdata = `DIO_UNMAPPED_READ;
        end

        // register writes take effect only at the completing edge
        if (wr_en) begin
            if (hit_p7_data) begin
                s_d.p7_data = pwdata[7:0];
            end
            if (hit_p8_data) begin
                s_d.p8_data = pwdata[7:0];
            end
            if (hit_p7_dir) begin
                s_d.p7_dir = pwdata[7:0];
            end
            if (hit_p8_dir) begin
                s_d.p8_dir = pwdata[7:0];
            end
            if (hit_ctrl) begin
                s_d.seg_sel = pwdata[`DIO_SEL_MSB:`DIO_SEL_LSB];
                s_d.extended_display_select     = pwdata[`DIO_SGX_BIT];
            end
        end

        // pin drivers: standby floats, sleep holds, otherwise follow function
        if (standby_mode) begin
            s_d.p7_oe  = 8'h00;
            s_d.p8_oe  = 8'h00;
            s_d.p7_out = 8'h00;
            s_d.p8_out = 8'h00;
        end else if (!sleep_mode) begin
            s_d.p7_out = p7_fn_out;
            s_d.p7_oe  = p7_fn_oe;
            s_d.p8_out = p8_fn_out;
            s_d.p8_oe  = p8_fn_oe;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------

    // reset clears every register, so all pins float as inputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q         <= '0;
            s_q.p7_data <= `DIO_DATA_RST;
            s_q.p8_data <= `DIO_DATA_RST;
            s_q.p7_dir  <= `DIO_DIR_RST;
            s_q.p8_dir  <= `DIO_DIR_RST;
            s_q.seg_sel <= `DIO_SEL_RST;
            s_q.extended_display_select     <= `DIO_SGX_RST;
            s_q.p7_oe   <= 8'h00;
            s_q.p8_oe   <= 8'h00;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from flops
    // ------------------------------------------------------------

    assign prdata     = s_q.prdata;
    assign pready     = s_q.pready;
    assign pslverr    = s_q.pslverr;
    assign p7_pin_out = s_q.p7_out;
    assign p7_pin_oe  = s_q.p7_oe;
    assign p8_pin_out = s_q.p8_out;
    assign p8_pin_oe  = s_q.p8_oe;

endmodule

`default_nettype wire

/* hw/pin_sync.sv */
// two-flop synchroniser for the sixteen port input pins
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // asynchronous pin levels in, synchronised levels out
    input  wire logic [15:0] pin_async,
    output logic      [15:0] pin_synced
);

    dual_io_pkg::pin_sync_state_t s_q;
    dual_io_pkg::pin_sync_state_t s_d;

    // first stage feeds only the second stage
    always_comb begin
        s_d      = s_q;
        s_d.meta = pin_async;
        s_d.sync = s_q.meta;
    end

    // state register, cleared by reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pin_synced = s_q.sync;

endmodule

`default_nettype wire

/* shared/dual_io_map.svh */
// register indices, field positions, reset values and access codes of the dual i/o port
`ifndef DUAL_IO_MAP_SVH
`define DUAL_IO_MAP_SVH

// register indices; the apb byte address is four times the index
`define DIO_P7_DATA_IDX      16'hffda
`define DIO_P8_DATA_IDX      16'hffdb
`define DIO_P7_DIR_IDX       16'hffea
`define DIO_P8_DIR_IDX       16'hffeb
`define DIO_DISP_CTRL_IDX    16'hfff0

// display_port_control field positions
`define DIO_SEL_LSB          0
`define DIO_SEL_MSB          3
`define DIO_SGX_BIT          4

// reset values
`define DIO_DATA_RST         8'h00
`define DIO_DIR_RST          8'h00
`define DIO_SEL_RST          4'h0
`define DIO_SGX_RST          1'b0

// value returned by a read of a write-only direction register
`define DIO_DIR_READ_VALUE   32'h0000_00ff

// read value of an unmapped address
`define DIO_UNMAPPED_READ    32'h0000_0000

`endif

/* shared/dual_io_pkg.sv */
// types of the dual i/o port block
package dual_io_pkg;

    // complete state of the port block
    typedef struct packed {
        logic [7:0]  p7_data;
        logic [7:0]  p8_data;
        logic [7:0]  p7_dir;
        logic [7:0]  p8_dir;
        logic [3:0]  seg_sel;
        logic        extended_display_select;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic [7:0]  p7_out;
        logic [7:0]  p7_oe;
        logic [7:0]  p8_out;
        logic [7:0]  p8_oe;
    } dio_state_t;

    // two stages of the pin-input synchroniser
    typedef struct packed {
        logic [15:0] meta;
        logic [15:0] sync;
    } pin_sync_state_t;

    // pin function chosen for one pin
    typedef enum logic [1:0] {
        FN_GPIO,
        FN_SEGMENT,
        FN_CLOCK
    } pin_fn_t;

endpackage

/* test/dual_io_port_asserts.sv */
// assertion checker for the dual i/o port block
`timescale 1ns/1ps
`default_nettype none
`include "dual_io_map.svh"

module dual_io_port_asserts (
    // clock, reset and bus
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // modes and display sources
    input wire logic        standby_mode,
    input wire logic        sleep_mode,
    input wire logic [15:0] segment_output,
    input wire logic        display_clock_one,
    // pins
    input wire logic [7:0]  p7_pin_out,
    input wire logic [7:0]  p7_pin_oe,
    input wire logic [7:0]  p8_pin_out,
    input wire logic [7:0]  p8_pin_oe
);
    // ----------------------------------------
    // shadow registers
    // ----------------------------------------
    logic [4:0] ctl_q;
    logic [7:0] d7_q;
    logic [7:0] r7_q;
    wire        wr_done = psel && penable && pready && pwrite && !pslverr;
    wire        setup_rd = psel && !penable && !pwrite;
    wire        run = !standby_mode && !sleep_mode;

    // track software writes so pin expectations need no peek inside
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= 5'h00;
            d7_q  <= 8'h00;
            r7_q  <= 8'h00;
        end else if (wr_done) begin
            if (paddr == {14'h0000, `DIO_DISP_CTRL_IDX, 2'b00}) ctl_q <= pwdata[4:0];
            if (paddr == {14'h0000, `DIO_P7_DATA_IDX, 2'b00}) d7_q <= pwdata[7:0];
            if (paddr == {14'h0000, `DIO_P7_DIR_IDX, 2'b00}) r7_q <= pwdata[7:0];
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    apb_zero_wait_a: assert property ((psel && !penable) |=> pready ##1 !pready)
        else $error("pready not a single cycle after setup");
    dir_reads_ones_a: assert property (
        setup_rd && paddr[31:2] == {14'h0000, `DIO_P7_DIR_IDX}
        |=> prdata == `DIO_DIR_READ_VALUE) else $error("direction read not all ones");
    read_stored_a: assert property (
        setup_rd && paddr == {14'h0000, `DIO_P7_DATA_IDX, 2'b00}
        |=> (prdata[7:0] & r7_q) == (d7_q & r7_q)) else $error("output bits not read from data");
    reset_float_a: assert property ($rose(presetn) |-> p7_pin_oe == 8'h00 && p8_pin_oe == 8'h00)
        else $error("pins driven at reset release");
    gpio_port_a: assert property ((ctl_q[3:2] == 2'b00 && run)
        |=> p7_pin_oe == $past(r7_q) && (p7_pin_out & p7_pin_oe) == ($past(d7_q) & $past(r7_q)))
        else $error("port 7 gpio pins wrong");
    seg_port_a: assert property ((ctl_q[3:2] != 2'b00 && run)
        |=> p7_pin_oe == 8'hff && p7_pin_out == $past(segment_output[7:0]))
        else $error("port 7 segment pins wrong");
    clock_pin_a: assert property ((ctl_q[4] && run)
        |=> p8_pin_oe[7] && p8_pin_out[7] == $past(display_clock_one))
        else $error("display clock pin wrong");
    seg_top_a: assert property ((!ctl_q[4] && ctl_q[3:1] != 3'h0 && run)
        |=> p8_pin_oe[7] && p8_pin_out[7] == $past(segment_output[15]))
        else $error("segment 32 pin wrong");
    standby_float_a: assert property (standby_mode |=> p7_pin_oe == 8'h00 && p8_pin_oe == 8'h00)
        else $error("pins driven in standby");
    sleep_hold_a: assert property ((sleep_mode && !standby_mode)
        |=> $stable(p7_pin_out) && $stable(p7_pin_oe) && $stable(p8_pin_oe))
        else $error("pins changed in sleep");

    // main scenarios reached
    cover property (wr_done && ctl_q[4]);
    cover property (pready && pslverr);
    cover property (sleep_mode ##1 !sleep_mode);
endmodule

bind dual_io_port dual_io_port_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .standby_mode(standby_mode), .sleep_mode(sleep_mode),
    .segment_output(segment_output), .display_clock_one(display_clock_one),
    .p7_pin_out(p7_pin_out), .p7_pin_oe(p7_pin_oe), .p8_pin_out(p8_pin_out),
    .p8_pin_oe(p8_pin_oe));
`default_nettype wire

/* test/pin_far_side.sv */
// model of the outside circuit on eight shared port pins
`timescale 1ns/1ps
`default_nettype none

module pin_far_side (
    // what the port drives
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    // outside driver level and contention command
    input  wire logic [7:0] ext_level,
    input  wire logic       fight,
    // level seen back by the port
    output logic      [7:0] pin_in
);
    // released bits follow the outside driver; fight lets it overpower the port
    assign pin_in = fight ? ext_level : (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule
`default_nettype wire

/* test/test_dual_io_port.sv */
// self-checking bench for the dual i/o port block
`timescale 1ns/1ps
`default_nettype none
`include "dual_io_map.svh"

module test_dual_io_port;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] paddr = 32'h0000_0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        standby_mode = 1'b0;
    logic        sleep_mode = 1'b0;
    logic [15:0] segment_output = 16'ha53c;
    logic        display_clock_one = 1'b0;
    logic        fight = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  p7_in, p7_out, p7_oe, p8_in, p8_out, p8_oe;
    logic [31:0] rdv;
    logic        erv;
    logic [7:0]  e8;
    int          err_count = 0;
    int          checked = 0;
    int          cycles = 0;

    dual_io_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .standby_mode(standby_mode), .sleep_mode(sleep_mode),
        .segment_output(segment_output), .display_clock_one(display_clock_one),
        .p7_pin_in(p7_in), .p7_pin_out(p7_out), .p7_pin_oe(p7_oe),
        .p8_pin_in(p8_in), .p8_pin_out(p8_out), .p8_pin_oe(p8_oe));
    pin_far_side u_far7 (.pin_out(p7_out), .pin_oe(p7_oe), .ext_level(8'h3c), .fight(fight),
        .pin_in(p7_in));
    pin_far_side u_far8 (.pin_out(p8_out), .pin_oe(p8_oe), .ext_level(8'hc3), .fight(1'b0),
        .pin_in(p8_in));

    // 20 mhz clock and a hang limit
    always #25 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            stop_test();
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one apb transfer; entered just after an edge, returns one edge after release
    task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {14'h0000, idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [15:0] idx, input logic [31:0] exp, input string nm);
        xfer(1'b0, idx, 32'h0000_0000);
        chk(nm, rdv, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        tick(2);
        chk("oe in reset", {p8_oe, p7_oe}, 32'h0000_0000);
        presetn <= 1'b1;
        // pin levels need two synchroniser edges after release before a read sees them
        tick(2);
        rd(`DIO_P7_DATA_IDX, 32'h0000_003c, "p7 pins");
        rd(`DIO_P7_DIR_IDX, 32'h0000_00ff, "p7 dir");
        rd(`DIO_P8_DIR_IDX, 32'h0000_00ff, "p8 dir");
        xfer(1'b1, `DIO_P7_DATA_IDX, 32'h0000_00a5);
        tick(2);
        chk("p7 oe input", {24'h0, p7_oe}, 32'h0000_0000);
        xfer(1'b1, `DIO_P7_DIR_IDX, 32'h0000_000f);
        rd(`DIO_P7_DIR_IDX, 32'h0000_00ff, "p7 dir set");
        tick(1);
        chk("p7 oe", {24'h0, p7_oe}, 32'h0000_000f);
        chk("p7 out", {24'h0, p7_out & 8'h0f}, 32'h0000_0005);
        // outside driver overpowers the outputs; reads must still show stored bits
        fight <= 1'b1;
        tick(4);
        rd(`DIO_P7_DATA_IDX, 32'h0000_0035, "p7 mixed");
        fight <= 1'b0;
        xfer(1'b1, `DIO_P8_DIR_IDX, 32'h0000_0080);
        // every select code with the extended bit off and on
        for (int c = 0; c < 32; c++) begin
            display_clock_one <= ~c[0];
            xfer(1'b1, `DIO_DISP_CTRL_IDX, 32'(c));
            tick(2);
            e8 = c[4] ? {7'h0, ~c[0]} : (c[3:1] != 3'h0) ? 8'h01 : 8'h00;
            chk("p7 oe mode", {24'h0, p7_oe}, (c[3:2] != 2'h0) ? 32'h0000_00ff : 32'h0000_000f);
            if (c[3:2] != 2'h0) chk("p7 seg", {24'h0, p7_out}, 32'h0000_003c);
            chk("p8 b7", {30'h0, p8_oe[7], p8_out[7]}, {30'h0, 1'b1, e8[0]});
            chk("p8 low", {18'h0, p8_oe[6:0], p8_out[6:0]},
                (c[3:1] != 3'h0) ? {18'h0, 7'h7f, 7'h25} : 32'h0000_0000);
        end
        xfer(1'b0, 16'h0000, 32'h0000_0000);
        chk("unmapped", {erv, rdv[30:0]}, 32'h8000_0000);
        xfer(1'b1, `DIO_DISP_CTRL_IDX, 32'h0000_0000);
        standby_mode <= 1'b1;
        tick(2);
        chk("standby oe", {p8_oe, p7_oe}, 32'h0000_0000);
        standby_mode <= 1'b0;
        tick(2);
        chk("active oe", {24'h0, p7_oe}, 32'h0000_000f);
        // port 8: top bit is an output holding zero, the rest read the outside levels
        rd(`DIO_P8_DATA_IDX, 32'h0000_0043, "p8 mixed");
        sleep_mode <= 1'b1;
        xfer(1'b1, `DIO_P7_DIR_IDX, 32'h0000_00ff);
        tick(2);
        chk("sleep oe", {24'h0, p7_oe}, 32'h0000_000f);
        sleep_mode <= 1'b0;
        tick(2);
        chk("wake oe", {24'h0, p7_oe}, 32'h0000_00ff);
        // second reset in mid-run
        presetn <= 1'b0;
        tick(1);
        chk("reset oe", {p8_oe, p7_oe}, 32'h0000_0000);
        presetn <= 1'b1;
        tick(4);
        rd(`DIO_P7_DATA_IDX, 32'h0000_003c, "p7 after reset");
        stop_test();
    end
endmodule
`default_nettype wire
